// [mmt_pkg.sv]
package mmt_pkg;
  // ---------------------------------------------------------------
  // Target address and framing
  // ---------------------------------------------------------------
  localparam logic [6:0] MMT_DEV_ADDR7 = 7'h50;
  localparam logic [3:0] MMT_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] MMT_CNT_ZERO = 4'h0;
  localparam logic [3:0] MMT_CNT_ONE = 4'h1;
  // ---------------------------------------------------------------
  // Status byte holding the data-not-ready flag
  // ---------------------------------------------------------------
  localparam logic [7:0] MMT_STATUS_BYTE = 8'h02;
  localparam int MMT_NOT_READY_BIT = 0;
  // ---------------------------------------------------------------
  // Link-side states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MMT_ST_IDLE,
    MMT_ST_DEV,
    MMT_ST_DACK,
    MMT_ST_MADDR,
    MMT_ST_MACKW,
    MMT_ST_TX,
    MMT_ST_MACK,
    MMT_ST_IGN
  } mmt_state_e;
endpackage

// [mmt_mem.sv]
`timescale 1ns/100ps
module mmt_mem #(
  parameter int DW = 8,
  parameter int AW = 8
) (
  // Write side
  input wire logic wr_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // Read side
  input wire logic rd_clk_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge wr_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge rd_clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

// [mmt_twowire_read.sv]
`timescale 1ns/100ps
module mmt_twowire_read
  import mmt_pkg::*;
#(
  parameter int AW = 8
) (
  // System side
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic data_not_ready_i,
  input wire logic mem_wr_en_i,
  input wire logic [AW-1:0] mem_wr_addr_i,
  input wire logic [7:0] mem_wr_data_i,
  output logic interrupt_out_n_o,
  // Link side
  input wire logic link_clk_i,
  input wire logic module_select_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  // Pointer arithmetic and the status byte decode assume an 8-bit byte store
  if (AW != 8) begin : g_aw_check
    $error("mmt_twowire_read: memory address must be 8 bits");
  end

  // ---------------------------------------------------------------
  // System domain: ready flag and interrupt
  // ---------------------------------------------------------------
  logic nr_r;
  logic int_n_r;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      nr_r <= 1'b1;
    end else begin
      nr_r <= data_not_ready_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      int_n_r <= 1'b1;
    end else if (nr_r && !data_not_ready_i) begin
      int_n_r <= 1'b0;
    end else if (!nr_r && data_not_ready_i) begin
      int_n_r <= 1'b1;
    end
  end

  assign interrupt_out_n_o = int_n_r;

  // ---------------------------------------------------------------
  // Crossing into the link domain
  // ---------------------------------------------------------------
  logic rst_m_r, link_rst_r;
  logic nr_m_r, nr_s_r;
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic sel_m_r, sel_s_r;

  always_ff @(posedge link_clk_i) begin
    rst_m_r <= reset_i;
    link_rst_r <= rst_m_r;
  end

  always_ff @(posedge link_clk_i) begin
    nr_m_r <= nr_r;
    nr_s_r <= nr_m_r;
    sel_m_r <= module_select_n_i;
    sel_s_r <= sel_m_r;
  end

  always_ff @(posedge link_clk_i) begin
    scl_m_r <= scl_i;
    scl_s_r <= scl_m_r;
    scl_d_r <= scl_s_r;
    sda_m_r <= sda_i;
    sda_s_r <= sda_m_r;
    sda_d_r <= sda_s_r;
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;
  assign bus_start = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign bus_stop = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

  // ---------------------------------------------------------------
  // Byte store and read path
  // ---------------------------------------------------------------
  logic [AW-1:0] ptr_r, ptr_nxt;
  logic [7:0] mem_q;
  logic [7:0] rd_byte;

  mmt_mem #(
    .DW(8),
    .AW(AW)
  ) u_mem (
    .wr_clk_i(sys_clk_i),
    .wr_en_i(mem_wr_en_i),
    .wr_addr_i(mem_wr_addr_i),
    .wr_data_i(mem_wr_data_i),
    .rd_clk_i(link_clk_i),
    .rd_addr_i(ptr_r),
    .rd_data_o(mem_q)
  );

  always_comb begin
    rd_byte = mem_q;
    if (ptr_r == MMT_STATUS_BYTE) begin
      rd_byte[MMT_NOT_READY_BIT] = nr_s_r;
    end
  end

  // ---------------------------------------------------------------
  // Link state machine
  // ---------------------------------------------------------------
  mmt_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic oe_r, oe_nxt;
  logic ack_r, ack_nxt;
  logic addr_hit;

  assign addr_hit = (shift_r[7:1] == MMT_DEV_ADDR7);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    oe_nxt = oe_r;
    ack_nxt = ack_r;
    ptr_nxt = ptr_r;
    if (sel_s_r) begin
      state_nxt = MMT_ST_IDLE;
      oe_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt = MMT_ST_DEV;
      cnt_nxt = MMT_CNT_ZERO;
      oe_nxt = 1'b0;
    end else if (bus_stop) begin
      state_nxt = MMT_ST_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        MMT_ST_DEV, MMT_ST_MADDR: begin
          if (scl_rise && cnt_r != MMT_BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_s_r};
            cnt_nxt = cnt_r + MMT_CNT_ONE;
          end else if (scl_fall && cnt_r == MMT_BITS_PER_BYTE) begin
            cnt_nxt = MMT_CNT_ZERO;
            if (state_r == MMT_ST_MADDR) begin
              ptr_nxt = shift_r;
              oe_nxt = 1'b1;
              state_nxt = MMT_ST_MACKW;
            end else if (addr_hit) begin
              oe_nxt = 1'b1;
              state_nxt = MMT_ST_DACK;
            end else begin
              state_nxt = MMT_ST_IGN;
            end
          end
        end
        MMT_ST_DACK: begin
          if (scl_fall) begin
            if (shift_r[0]) begin
              shift_nxt = rd_byte;
              oe_nxt = !rd_byte[7];
              state_nxt = MMT_ST_TX;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = MMT_ST_MADDR;
            end
          end
        end
        MMT_ST_MACKW: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            state_nxt = MMT_ST_IGN;
          end
        end
        MMT_ST_TX: begin
          if (scl_rise) begin
            cnt_nxt = cnt_r + MMT_CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_r == MMT_BITS_PER_BYTE) begin
              cnt_nxt = MMT_CNT_ZERO;
              oe_nxt = 1'b0;
              ptr_nxt = ptr_r + 8'h01;
              state_nxt = MMT_ST_MACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = !shift_r[6];
            end
          end
        end
        MMT_ST_MACK: begin
          if (scl_rise) begin
            ack_nxt = !sda_s_r;
          end else if (scl_fall) begin
            if (ack_r) begin
              shift_nxt = rd_byte;
              oe_nxt = !rd_byte[7];
              state_nxt = MMT_ST_TX;
            end else begin
              state_nxt = MMT_ST_IGN;
            end
          end
        end
        default: begin
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_r) begin
      state_r <= MMT_ST_IDLE;
      cnt_r <= MMT_CNT_ZERO;
      shift_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ack_r <= ack_nxt;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_r) begin
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (link_rst_r) begin
      ptr_r <= 8'h00;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_nr_clear;
    nr_r ##1 !nr_r;
  endsequence

  sequence s_last_tx_bit;
    scl_fall && !sel_s_r && !bus_start && !bus_stop && state_r == MMT_ST_TX
      && cnt_r == MMT_BITS_PER_BYTE;
  endsequence

  chk_desel_quiet: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    sel_s_r |=> !oe_r && state_r == MMT_ST_IDLE)
    else $error("bus driven while deselected");

  chk_ack_match: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    state_r == MMT_ST_DACK |-> shift_r[7:1] == MMT_DEV_ADDR7 && oe_r)
    else $error("address acknowledged without match");

  chk_nack_miss: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    (scl_fall && !sel_s_r && !bus_start && !bus_stop && state_r == MMT_ST_DEV
      && cnt_r == MMT_BITS_PER_BYTE && !addr_hit)
      |=> state_r == MMT_ST_IGN && !oe_r)
    else $error("mismatched address not ignored");

  chk_start_sel: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    (bus_start && !sel_s_r) |=> state_r == MMT_ST_DEV && cnt_r == MMT_CNT_ZERO)
    else $error("start not taken");

  chk_read_dir: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    (scl_fall && !sel_s_r && !bus_start && !bus_stop && state_r == MMT_ST_DACK)
      |=> (state_r == MMT_ST_TX) == $past(shift_r[0]))
    else $error("direction bit misread");

  chk_ptr_step: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    s_last_tx_bit |=> ptr_r == $past(ptr_r) + 8'h01 && !oe_r ##1 ptr_r == $past(ptr_r))
    else $error("pointer did not advance by one");

  chk_addr_load: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    (scl_fall && !sel_s_r && !bus_start && !bus_stop && state_r == MMT_ST_MADDR
      && cnt_r == MMT_BITS_PER_BYTE) |=> ptr_r == $past(shift_r) && oe_r)
    else $error("memory address not loaded");

  chk_stop_free: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    bus_stop |=> !oe_r && state_r == MMT_ST_IDLE)
    else $error("line held after stop");

  chk_next_byte: assert property (@(posedge link_clk_i) disable iff (link_rst_r)
    (scl_fall && !sel_s_r && !bus_start && !bus_stop && state_r == MMT_ST_MACK && ack_r)
      |=> state_r == MMT_ST_TX && oe_r == !$past(rd_byte[7]))
    else $error("next byte not sent after ack");

  chk_int_ready: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_nr_clear |-> !int_n_r)
    else $error("interrupt not asserted on ready");
endmodule

// [mmt_host_model.sv]
`timescale 1ns/100ps
module mmt_host_model (
  // Timing reference
  input wire logic link_clk_i,
  // Bus wires
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // Wire changes land on the falling reference edge, away from the target's sampling edge
  task automatic hp();
    repeat (12) @(negedge link_clk_i);
  endtask
  // Data held a few clocks past the falling clock edge
  task automatic fall();
    scl_o = 1'b0;
    repeat (4) @(negedge link_clk_i);
  endtask
  task automatic bit_out(input logic b);
    sda_pull_o = ~b;
    hp();
    scl_o = 1'b1;
    hp();
    fall();
  endtask
  task automatic bit_in(output logic b);
    sda_pull_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    b = sda_i;
    fall();
  endtask
  task automatic start();
    sda_pull_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_pull_o = 1'b1;
    hp();
    fall();
  endtask
  task automatic stop();
    sda_pull_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_pull_o = 1'b0;
    hp();
  endtask
  // MSB first, then the target's acknowledge slot
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    bit_in(a);
    ack = ~a;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) bit_in(v[i]);
    bit_out(~more);
  endtask
endmodule

// [mmt_twowire_read_bench.sv]
`timescale 1ns/100ps
module mmt_twowire_read_bench;
  logic sys_clk, reset, not_ready, wr_en, int_n, link_clk, sel_n, scl, sda_o, sda_oe, pull;
  logic [7:0] wr_addr, wr_data;
  wire sda_w = ~pull & (sda_oe ? sda_o : 1'b1);
  logic [7:0] mem [256];
  int ptr, seed, r, bad_count, comparisons;
  logic oe_bad;
  mmt_twowire_read uut (.sys_clk_i(sys_clk), .reset_i(reset), .data_not_ready_i(not_ready),
    .mem_wr_en_i(wr_en), .mem_wr_addr_i(wr_addr), .mem_wr_data_i(wr_data),
    .interrupt_out_n_o(int_n), .link_clk_i(link_clk), .module_select_n_i(sel_n),
    .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe));
  mmt_host_model host (.link_clk_i(link_clk), .sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  initial oe_bad = 1'b0;
  always @(posedge link_clk) if (sel_n && sda_oe) oe_bad = 1'b1;
  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    give_verdict();
  end
  function automatic logic [7:0] exp_byte(input int p);
    exp_byte = mem[p];
    if (p == 2) exp_byte[0] = not_ready;
  endfunction
  // ---------------------------------------------------------------
  // Transfers
  // ---------------------------------------------------------------
  task automatic xfer(input logic rnd, input logic [7:0] a, input int n);
    logic ack;
    logic [7:0] v;
    if (rnd) begin
      host.start();
      host.wbyte(8'hA0, ack);
      chk({7'h00, ack}, 8'h01);
      host.wbyte(a, ack);
      chk({7'h00, ack}, 8'h01);
      ptr = a;
    end
    host.start();
    host.wbyte(8'hA1, ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      host.rbyte(i < n - 1, v);
      chk(v, exp_byte(ptr));
      ptr = (ptr + 1) % 256;
    end
    host.stop();
    chk({7'h00, sda_oe}, 8'h00);
    $display("read of %0d bytes done", n);
  endtask
  task automatic nak(input logic [7:0] dev, input logic sel);
    logic ack;
    @(negedge sys_clk);
    sel_n = sel;
    repeat (2) @(negedge sys_clk);
    host.start();
    host.wbyte(dev, ack);
    chk({7'h00, ack}, 8'h00);
    host.stop();
    @(negedge sys_clk);
    sel_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    $display("ignored address %h done", dev);
  endtask
  initial begin
    seed = 56;
    bad_count = 0;
    comparisons = 0;
    reset = 1'b1;
    not_ready = 1'b1;
    wr_en = 1'b0;
    wr_addr = 8'h00;
    wr_data = 8'h00;
    sel_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    for (int i = 0; i < 256; i++) begin
      @(negedge sys_clk);
      r = $random(seed);
      wr_en = 1'b1;
      wr_addr = i[7:0];
      wr_data = r[7:0];
      mem[i] = r[7:0];
    end
    @(negedge sys_clk);
    wr_en = 1'b0;
    chk({7'h00, int_n}, 8'h01);
    not_ready = 1'b0;
    for (int i = 0; i < 10 && int_n !== 1'b0; i++) @(negedge sys_clk);
    chk({7'h00, int_n}, 8'h00);
    $display("ready interrupt done");
    xfer(1'b1, 8'h01, 3);
    xfer(1'b0, 8'h00, 1);
    nak(8'hA2, 1'b0);
    nak(8'hB1, 1'b0);
    nak(8'hA1, 1'b1);
    xfer(1'b0, 8'h00, 2);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      xfer(1'b1, r[7:0], 2);
    end
    xfer(1'b1, 8'hFF, 2);
    // Mid-run reset: pointer returns to zero, stored bytes survive
    @(negedge sys_clk);
    reset = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({7'h00, int_n}, 8'h01);
    reset = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk({7'h00, int_n}, 8'h00);
    ptr = 0;
    xfer(1'b0, 8'h00, 2);
    chk({7'h00, oe_bad}, 8'h00);
    give_verdict();
  end
endmodule
